//--- design/async_serial_transmitter.sv
// asynchronous serial transmitter with axi4-lite register slave
`timescale 1ns/1ps
module async_serial_transmitter (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic tx_line_out,
  output logic tx_irq_out
);
  import serial_tx_pkg::*;

  typedef enum logic [2:0] {idle_st, start_st, data_st, ninth_st,
    stop_st, break_st} tx_state_type;

  function automatic logic is_addr(input logic [7:0] a,
      input logic [7:0] b);
    is_addr = (a[7:2] == b[7:2]);
  endfunction

  // bus state
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic wstrb0_reg, wstrb0_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  // software registers
  logic clocked_reg, clocked_next, high_baud_reg, high_baud_next;
  logic tx_en_reg, tx_en_next, ninth_en_reg, ninth_en_next;
  logic ninth_val_reg, ninth_val_next, brk_req_reg, brk_req_next;
  logic wide_reg, wide_next, port_en_reg, port_en_next;
  logic irq_en_reg, irq_en_next;
  logic [7:0] div_lo_reg, div_lo_next, div_hi_reg, div_hi_next;
  // transmit datapath
  logic [7:0] buffer_reg, buffer_next;
  logic buffer_full_reg, buffer_full_next;
  logic buf_ninth_reg, buf_ninth_next;
  logic [1:0] settle_reg, settle_next;
  logic [8:0] shift_reg, shift_next;
  logic shift_busy_reg, shift_busy_next;
  tx_state_type state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [15:0] brg_cnt_reg, brg_cnt_next;
  logic [5:0] tick_cnt_reg, tick_cnt_next;
  logic line_reg, line_next;
  logic brg_tick, bit_tick, do_write, do_read, active, load_now;
  logic wr_data, buf_empty_flag;
  logic [15:0] divisor;
  logic [5:0] tick_top;

  // (clocked mode blocks the asynchronous path)
  assign active = port_en_reg && !clocked_reg && tx_en_reg;
  // one divisor and one frame format serve the whole line
  assign divisor = wide_reg ? {div_hi_reg, div_lo_reg} : {8'h00, div_lo_reg};
  // (x16 when high baud or wide divider, else x64)
  assign tick_top = (high_baud_reg || wide_reg) ? ticks_x16 : ticks_x64;
  assign brg_tick = (brg_cnt_reg == 16'h0000);
  assign bit_tick = brg_tick && (tick_cnt_reg == 6'h00);
  // flag reads as still empty until settled
  assign buf_empty_flag = !buffer_full_reg || (settle_reg != 2'h0);
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign do_read = s_axi_arvalid_in && !rvalid_reg;
  assign wr_data = do_write && is_addr(awaddr_reg, tx_data_addr) &&
    wstrb0_reg;
  // load when idle, or on the tick that ends a stop bit
  assign load_now = active && buffer_full_reg && !brk_req_reg &&
    ((state_reg == idle_st && !shift_busy_reg) ||
    (state_reg == stop_st && bit_tick));

  // bus handshake outputs
  assign s_axi_awready_out = !aw_held_reg;
  assign s_axi_wready_out = !w_held_reg;
  assign s_axi_arready_out = !rvalid_reg;
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rresp_out = rresp_reg;
  assign s_axi_rdata_out = rdata_reg;
  // (enable gates only the request line)
  assign tx_irq_out = irq_en_reg && tx_en_reg && buf_empty_flag;
  assign tx_line_out = line_reg;

  // register slave next state; write and read channels independent
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb0_next = wstrb0_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    clocked_next = clocked_reg;
    high_baud_next = high_baud_reg;
    tx_en_next = tx_en_reg;
    ninth_en_next = ninth_en_reg;
    ninth_val_next = ninth_val_reg;
    brk_req_next = brk_req_reg;
    wide_next = wide_reg;
    port_en_next = port_en_reg;
    irq_en_next = irq_en_reg;
    div_lo_next = div_lo_reg;
    div_hi_next = div_hi_reg;
    if (s_axi_awvalid_in && !aw_held_reg) begin
      aw_held_next = 1'b1;
      awaddr_next = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !w_held_reg) begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata_in;
      wstrb0_next = s_axi_wstrb_in[0];
    end
    if (bvalid_reg && s_axi_bready_in) begin
      bvalid_next = 1'b0;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = resp_okay;
      // buffer-empty and shift-empty bits are not writable
      if (is_addr(awaddr_reg, ctrl_addr)) begin
        if (wstrb0_reg) begin
          ninth_val_next = wdata_reg[ninth_value_pos];
          high_baud_next = wdata_reg[high_baud_pos];
          brk_req_next = wdata_reg[send_break_pos] | brk_req_reg;
          clocked_next = wdata_reg[clocked_mode_pos];
          tx_en_next = wdata_reg[tx_enable_pos];
          ninth_en_next = wdata_reg[ninth_enable_pos];
        end
      end else if (is_addr(awaddr_reg, baud_ctrl_addr)) begin
        if (wstrb0_reg) begin
          wide_next = wdata_reg[wide_divider_pos];
          port_en_next = wdata_reg[port_enable_pos];
          irq_en_next = wdata_reg[irq_enable_pos];
        end
      end else if (is_addr(awaddr_reg, divisor_lo_addr)) begin
        if (wstrb0_reg) begin
          div_lo_next = wdata_reg[7:0];
        end
      end else if (is_addr(awaddr_reg, divisor_hi_addr)) begin
        if (wstrb0_reg) begin
          div_hi_next = wdata_reg[7:0];
        end
      end else if (is_addr(awaddr_reg, tx_data_addr)) begin
        bresp_next = resp_okay;
      end else begin
        bresp_next = resp_slverr;
      end
    end
    // consumed on the tick that starts the break; a request written in
    // that same cycle survives, so the set wins
    if (state_reg == idle_st && active && !shift_busy_reg &&
        brk_req_reg && bit_tick) begin
      brk_req_next = do_write && is_addr(awaddr_reg, ctrl_addr) &&
        wstrb0_reg && wdata_reg[send_break_pos];
    end
    if (rvalid_reg && s_axi_rready_in) begin
      rvalid_next = 1'b0;
    end
    if (do_read) begin
      rvalid_next = 1'b1;
      rresp_next = resp_okay;
      rdata_next = 32'h0000_0000;
      // shift register itself has no address
      if (is_addr(s_axi_araddr_in, ctrl_addr)) begin
        rdata_next[buffer_empty_pos] = buf_empty_flag;
        rdata_next[ninth_enable_pos] = ninth_en_reg;
        rdata_next[tx_enable_pos] = tx_en_reg;
        rdata_next[clocked_mode_pos] = clocked_reg;
        rdata_next[send_break_pos] = brk_req_reg;
        rdata_next[high_baud_pos] = high_baud_reg;
        rdata_next[shift_empty_pos] = !shift_busy_reg;
        rdata_next[ninth_value_pos] = ninth_val_reg;
      end else if (is_addr(s_axi_araddr_in, baud_ctrl_addr)) begin
        rdata_next[port_enable_pos] = port_en_reg;
        rdata_next[wide_divider_pos] = wide_reg;
        rdata_next[irq_enable_pos] = irq_en_reg;
      end else if (is_addr(s_axi_araddr_in, divisor_lo_addr)) begin
        rdata_next[7:0] = div_lo_reg;
      end else if (is_addr(s_axi_araddr_in, divisor_hi_addr)) begin
        rdata_next[7:0] = div_hi_reg;
      end else if (is_addr(s_axi_araddr_in, tx_data_addr)) begin
        rdata_next[7:0] = buffer_reg;
      end else begin
        rresp_next = resp_slverr;
      end
    end
  end

  // transmit buffer, baud generator and frame sequencer
  always_comb begin
    buffer_next = buffer_reg;
    buffer_full_next = buffer_full_reg;
    buf_ninth_next = buf_ninth_reg;
    settle_next = (settle_reg != 2'h0) ? settle_reg - 2'h1 : 2'h0;
    shift_next = shift_reg;
    shift_busy_next = shift_busy_reg;
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    line_next = line_reg;
    brg_cnt_next = brg_tick ? divisor : brg_cnt_reg - 16'h0001;
    tick_cnt_next = tick_cnt_reg;
    if (brg_tick) begin
      tick_cnt_next = (tick_cnt_reg == 6'h00) ? tick_top :
        tick_cnt_reg - 6'h01;
    end
    // (transfer empties the buffer in the same cycle)
    if (load_now) begin
      shift_next = {ninth_en_reg & buf_ninth_reg, buffer_reg};
      shift_busy_next = 1'b1;
      buffer_full_next = 1'b0;
    end
    // (a write fills the buffer; flag settles after it)
    if (wr_data) begin
      buffer_next = wdata_reg[7:0];
      buf_ninth_next = ninth_val_reg;
      buffer_full_next = 1'b1;
      settle_next = flag_settle;
    end
    // (enable rising empties buffer so the flag sets)
    if (tx_en_next && !tx_en_reg) begin
      buffer_full_next = wr_data;
    end
    if (!active) begin
      state_next = idle_st;
      line_next = 1'b1;
      shift_busy_next = 1'b0;
    end else begin
      case (state_reg)
        idle_st: begin
          line_next = 1'b1;
          if (bit_tick && shift_busy_reg) begin
            state_next = start_st;
            line_next = 1'b0;
          end else if (bit_tick && brk_req_reg) begin
            // (start plus twelve low bit periods)
            state_next = break_st;
            line_next = 1'b0;
            bit_cnt_next = break_bits;
            shift_busy_next = 1'b1;
          end
        end
        start_st: begin
          if (bit_tick) begin
            state_next = data_st;
            line_next = shift_reg[0];
            shift_next = {1'b0, shift_reg[8:1]};
            bit_cnt_next = 4'h7;
          end
        end
        data_st: begin
          if (bit_tick) begin
            if (bit_cnt_reg != 4'h1 && bit_cnt_reg != 4'h0) begin
              line_next = shift_reg[0];
              shift_next = {1'b0, shift_reg[8:1]};
              bit_cnt_next = bit_cnt_reg - 4'h1;
            end else if (bit_cnt_reg == 4'h1) begin
              line_next = shift_reg[0];
              shift_next = {1'b0, shift_reg[8:1]};
              bit_cnt_next = 4'h0;
            end else if (ninth_en_reg) begin
              // (ninth bit carries software parity)
              state_next = ninth_st;
              line_next = shift_reg[0];
            end else begin
              state_next = stop_st;
              line_next = 1'b1;
            end
          end
        end
        ninth_st: begin
          if (bit_tick) begin
            state_next = stop_st;
            line_next = 1'b1;
          end
        end
        break_st: begin
          if (bit_tick) begin
            if (bit_cnt_reg == 4'h0) begin
              state_next = stop_st;
              line_next = 1'b1;
            end else begin
              bit_cnt_next = bit_cnt_reg - 4'h1;
            end
          end
        end
        stop_st: begin
          if (bit_tick) begin
            // reload at once, so shift-empty never blinks between
            // back-to-back frames
            state_next = load_now ? start_st : idle_st;
            line_next = !load_now;
            shift_busy_next = load_now;
          end
        end
        default: begin
          state_next = idle_st;
        end
      endcase
    end
  end

  // all state registers
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= resp_okay;
      rvalid_reg <= 1'b0;
      rresp_reg <= resp_okay;
      rdata_reg <= 32'h0000_0000;
      clocked_reg <= ctrl_reset[clocked_mode_pos];
      high_baud_reg <= ctrl_reset[high_baud_pos];
      tx_en_reg <= ctrl_reset[tx_enable_pos];
      ninth_en_reg <= ctrl_reset[ninth_enable_pos];
      ninth_val_reg <= ctrl_reset[ninth_value_pos];
      brk_req_reg <= ctrl_reset[send_break_pos];
      wide_reg <= baud_ctrl_reset[wide_divider_pos];
      port_en_reg <= baud_ctrl_reset[port_enable_pos];
      irq_en_reg <= baud_ctrl_reset[irq_enable_pos];
      div_lo_reg <= divisor_reset;
      div_hi_reg <= divisor_reset;
      buffer_reg <= 8'h00;
      buffer_full_reg <= 1'b0;
      buf_ninth_reg <= 1'b0;
      settle_reg <= 2'h0;
      shift_reg <= 9'h000;
      shift_busy_reg <= 1'b0;
      state_reg <= idle_st;
      bit_cnt_reg <= 4'h0;
      brg_cnt_reg <= 16'h0000;
      tick_cnt_reg <= 6'h00;
      line_reg <= 1'b1;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb0_reg <= wstrb0_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      clocked_reg <= clocked_next;
      high_baud_reg <= high_baud_next;
      tx_en_reg <= tx_en_next;
      ninth_en_reg <= ninth_en_next;
      ninth_val_reg <= ninth_val_next;
      brk_req_reg <= brk_req_next;
      wide_reg <= wide_next;
      port_en_reg <= port_en_next;
      irq_en_reg <= irq_en_next;
      div_lo_reg <= div_lo_next;
      div_hi_reg <= div_hi_next;
      buffer_reg <= buffer_next;
      buffer_full_reg <= buffer_full_next;
      buf_ninth_reg <= buf_ninth_next;
      settle_reg <= settle_next;
      shift_reg <= shift_next;
      shift_busy_reg <= shift_busy_next;
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      brg_cnt_reg <= brg_cnt_next;
      tick_cnt_reg <= tick_cnt_next;
      line_reg <= line_next;
    end
  end

  // checks on the transmit path
  sequence start_bit_seq;
    state_reg == start_st && !line_reg;
  endsequence
  line_idle_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    state_reg == idle_st |-> line_reg)
    else $error("line not high while idle");
  stop_high_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    state_reg == stop_st |-> line_reg)
    else $error("stop bit not high");
  start_low_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(state_reg == start_st) |-> start_bit_seq)
    else $error("start bit not low");
  load_one_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    load_now && !wr_data |=> !buffer_full_reg && shift_busy_reg)
    else $error("buffer transfer took more than one cycle");
  flag_settle_a: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    wr_data |=> buf_empty_flag ##1 buf_empty_flag)
    else $error("buffer flag cleared too early");
  shift_empty_a: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    state_reg != idle_st |-> shift_busy_reg)
    else $error("shift empty while sending");
  clocked_off_a: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    clocked_reg |=> state_reg == idle_st)
    else $error("frame ran in clocked mode");
  enable_flag_a: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    $rose(tx_en_reg) && !$past(wr_data) |-> buf_empty_flag)
    else $error("enable did not set buffer flag");
endmodule

//--- design/serial_tx_pkg.sv
// constants shared by the asynchronous serial transmitter
package serial_tx_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] baud_ctrl_addr = 8'h04;
  localparam logic [7:0] divisor_lo_addr = 8'h08;
  localparam logic [7:0] divisor_hi_addr = 8'h0c;
  localparam logic [7:0] tx_data_addr = 8'h10;
  // transmit_status_control field positions
  localparam int ninth_value_pos = 0;
  localparam int shift_empty_pos = 1;
  localparam int high_baud_pos = 2;
  localparam int send_break_pos = 3;
  localparam int clocked_mode_pos = 4;
  localparam int tx_enable_pos = 5;
  localparam int ninth_enable_pos = 6;
  localparam int buffer_empty_pos = 7;
  // baud_control field positions
  localparam int wide_divider_pos = 3;
  localparam int port_enable_pos = 7;
  localparam int irq_enable_pos = 0;
  // reset values
  localparam logic [7:0] ctrl_reset = 8'h02;
  localparam logic [7:0] baud_ctrl_reset = 8'h00;
  localparam logic [7:0] divisor_reset = 8'h00;
  // oversampling ratios
  localparam logic [5:0] ticks_x16 = 6'h0f;
  localparam logic [5:0] ticks_x64 = 6'h3f;
  // break character low bit periods after the start bit
  localparam logic [3:0] break_bits = 4'hc;
  // buffer-empty flag keeps reading empty for the first two cycles after a write
  localparam logic [1:0] flag_settle = 2'h2;
  // axi response codes
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

//--- dv/serial_rx_model.sv
// behavioural far-end receiver that decodes frames on the transmit line
`timescale 1ns/1ps
module serial_rx_model (
  input wire logic clk_in,
  input wire logic line_in,
  input wire logic [31:0] bit_clks_in,
  input wire logic nine_in,
  output logic got_valid_out,
  output logic [8:0] got_data_out,
  output logic stop_err_out
);
  int n;
  int i;
  logic [8:0] sh;

  // one frame per pass; start is confirmed at mid bit so glitches drop out
  initial begin
    got_valid_out = 1'b0;
    got_data_out = 9'h000;
    stop_err_out = 1'b0;
    forever begin
      while (line_in !== 1'b0) @(posedge clk_in);
      repeat (bit_clks_in / 2) @(posedge clk_in);
      if (line_in === 1'b0) begin
        n = nine_in ? 9 : 8;
        sh = 9'h000;
        for (i = 0; i < n; i++) begin
          repeat (bit_clks_in) @(posedge clk_in);
          sh[i] = line_in;
        end
        repeat (bit_clks_in) @(posedge clk_in);
        stop_err_out <= (line_in !== 1'b1);
        got_data_out <= sh;
        got_valid_out <= 1'b1;
        @(posedge clk_in);
        got_valid_out <= 1'b0;
      end
      // a low stop level would restart at once, so wait for the line high
      while (line_in !== 1'b1) @(posedge clk_in);
    end
  end
endmodule

//--- dv/tb_top.sv
// self-checking bench for the asynchronous serial transmitter
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module tb_top;
  import serial_tx_pkg::*;
  logic sys_clk, rst_n;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata, rd_data, rng, hold_v;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, tx_line, tx_irq;
  logic [1:0] bresp, rresp, rd_resp;
  logic nine_mode, got_valid, stop_err;
  logic [8:0] got_data;
  // note: {stop level expected low, ninth bit, data byte}
  logic [9:0] exp_v;
  logic [9:0] exp_q[$];
  int bit_clks, error_cnt, n_checks;
  logic [7:0] bc_tab [4] = '{8'h81, 8'h80, 8'h88, 8'h88};
  logic [7:0] ct_tab [4] = '{8'h24, 8'h20, 8'h20, 8'h20};
  logic [7:0] lo_tab [4] = '{8'h01, 8'h00, 8'h02, 8'h00};
  logic [7:0] hi_tab [4] = '{8'h00, 8'h00, 8'h00, 8'h01};
  int clk_tab [4] = '{32, 64, 48, 4112};

  async_serial_transmitter u_async_serial_transmitter (
    .sys_clk_in(sys_clk), .rst_n_in(rst_n),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .tx_line_out(tx_line), .tx_irq_out(tx_irq)
  );

  serial_rx_model u_serial_rx_model (
    .clk_in(sys_clk), .line_in(tx_line), .bit_clks_in(bit_clks),
    .nine_in(nine_mode), .got_valid_out(got_valid),
    .got_data_out(got_data), .stop_err_out(stop_err)
  );

  // free-running 100 mhz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] next_rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // one write; aw and w released independently as each is taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_on, w_on;
    aw_on = 1'b1;
    w_on = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_on || w_on) begin
      @(posedge sys_clk);
      if (aw_on && awready === 1'b1) begin
        aw_on = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_on && wready === 1'b1) begin
        w_on = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    // spare edge so the next request never lands in the same step
    @(posedge sys_clk);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // divisor first, rate bits next, transmitter enable last
  // the irq enable bit goes out with the rate bits in the baud control write
  task automatic prog(input int i);
    bit_clks = clk_tab[i];
    axi_wr(divisor_lo_addr, {24'h0, lo_tab[i]});
    axi_wr(divisor_hi_addr, {24'h0, hi_tab[i]});
    axi_wr(ctrl_addr, {24'h0, ct_tab[i] & 8'hdf});
    axi_wr(baud_ctrl_addr, {24'h0, bc_tab[i]});
    axi_wr(ctrl_addr, {24'h0, ct_tab[i]});
  endtask

  task automatic send_rnd(input logic b9);
    logic [31:0] v;
    v = next_rnd();
    exp_q.push_back({1'b0, b9, v[7:0]});
    axi_wr(tx_data_addr, {24'h0, v[7:0]});
  endtask

  // polls the shift-empty bit; software has no other completion signal
  task automatic wait_idle();
    do axi_rd(ctrl_addr); while (rd_data[shift_empty_pos] !== 1'b1);
    `CHK(exp_q.size(), 0)
  endtask

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask

  task automatic stop_test();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // frames seen on the line are matched against the oldest note
  always @(posedge sys_clk) begin
    if (got_valid === 1'b1) begin
      `CHK(exp_q.size() != 0, 1'b1)
      if (exp_q.size() != 0) begin
        exp_v = exp_q.pop_front();
        `CHK(got_data, exp_v[8:0])
        `CHK(stop_err, exp_v[9])
      end
    end
  end

  // the slowest rate dominates: about 45k cycles in all, so allow margin
  initial begin
    repeat (70000) @(posedge sys_clk);
    error_cnt++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    rst_n = 1'b0;
    rng = 32'd66062;
    nine_mode = 1'b0;
    bit_clks = 32;
    error_cnt = 0;
    n_checks = 0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    axi_rd(ctrl_addr);
    `CHK(rd_data & 32'h02, 32'h02)
    axi_rd(8'h14);
    `CHK(rd_resp, resp_slverr)
    end_test("reset");
    prog(0);
    axi_rd(ctrl_addr);
    `CHK(rd_data & 32'h82, 32'h82)
    `CHK(tx_irq, 1'b1)
    // second character waits in the buffer behind the first
    send_rnd(1'b0);
    send_rnd(1'b0);
    repeat (flag_settle) @(posedge sys_clk);
    axi_rd(ctrl_addr);
    `CHK(rd_data & 32'h82, 32'h00)
    `CHK(tx_irq, 1'b0)
    wait_idle();
    axi_wr(ctrl_addr, 32'h24);
    axi_rd(ctrl_addr);
    `CHK(rd_data & 32'h82, 32'h82)
    end_test("back_to_back");
    nine_mode = 1'b1;
    axi_wr(ctrl_addr, 32'h65);
    send_rnd(1'b1);
    wait_idle();
    axi_wr(ctrl_addr, 32'h64);
    send_rnd(1'b0);
    wait_idle();
    nine_mode = 1'b0;
    end_test("ninth_bit");
    // clocked mode holds the line; the buffered byte waits for its end
    hold_v = next_rnd();
    axi_wr(ctrl_addr, 32'h34);
    axi_wr(tx_data_addr, {24'h0, hold_v[7:0]});
    repeat (400) @(posedge sys_clk);
    axi_rd(ctrl_addr);
    `CHK(rd_data & 32'h82, 32'h02)
    `CHK(tx_line, 1'b1)
    exp_q.push_back({2'b00, hold_v[7:0]});
    axi_wr(ctrl_addr, 32'h24);
    wait_idle();
    end_test("clocked_mode");
    // break: receiver sees zero data and a low level where stop should be
    exp_q.push_back({1'b1, 9'h000});
    axi_wr(ctrl_addr, 32'h2c);
    do axi_rd(ctrl_addr); while (rd_data[send_break_pos] !== 1'b0);
    wait_idle();
    end_test("break");
    for (int i = 1; i < 4; i++) begin
      prog(i);
      send_rnd(1'b0);
      wait_idle();
    end
    end_test("rates");
    stop_test();
  end
endmodule
